//--- logic/sweep_pkg.sv
// Purpose: Shared constants and types for the fast-sweep packet framer.
// Assumes: One byte-wide link toward the host, one clock domain.
// Notes:   Field placement inside a group word is fixed in group_packer for both formats.
package sweep_pkg;

	// Packet geometry
	localparam int unsigned LEG_GROUPS   = 16;
	localparam int unsigned LEG_GBYTES   = 5;
	localparam int unsigned EXT_GROUPS   = 32;
	localparam int unsigned EXT_GBYTES   = 4;
	localparam int unsigned HDR_BYTES    = 4;
	localparam int unsigned GRP_BITS     = 40;
	localparam int unsigned IDX_W        = 5;
	localparam int unsigned SUB_W        = 3;
	localparam int unsigned HDR_W        = 3;

	// Marker nibbles
	localparam logic [3:0] MARK_FIRST    = 4'ha;
	localparam logic [3:0] MARK_SECOND   = 4'h5;

	// Header byte positions
	localparam logic [HDR_W-1:0] HB_MARK0 = 3'h0;
	localparam logic [HDR_W-1:0] HB_MARK1 = 3'h1;
	localparam logic [HDR_W-1:0] HB_HEAD0 = 3'h2;
	localparam logic [HDR_W-1:0] HB_HEAD1 = 3'h3;
	localparam logic [HDR_W-1:0] HB_DONE  = 3'h4;
	localparam logic [HDR_W-1:0] HB_TAIL  = 3'h5;  // Last byte out, packet closes

	// Last index values
	localparam logic [IDX_W-1:0] LEG_LAST_GRP = 5'h0f;
	localparam logic [IDX_W-1:0] EXT_LAST_GRP = 5'h1f;
	localparam logic [SUB_W-1:0] LEG_LAST_SUB = 3'h4;
	localparam logic [SUB_W-1:0] EXT_LAST_SUB = 3'h3;

	// Mode field value that selects the legacy format
	localparam logic [7:0] MODE_LEGACY   = 8'h00;

	// Framer states
	typedef enum logic [2:0]
	{
		ST_IDLE    = 3'b001,
		ST_COLLECT = 3'b010,
		ST_SEND    = 3'b100
	} fr_state_t;

	// One measurement group offered by the sampling side
	typedef struct packed
	{
		logic [14:0] heading;       // Raw angle, unsigned q6 degrees
		logic [15:0] range_first;   // Earlier sample, mm, zero is invalid
		logic [15:0] range_second;  // Later sample, mm, zero is invalid
		logic [3:0]  corr_first;    // Signed q3 correction, msb is sign
		logic [3:0]  corr_second;   // Signed q3 correction, msb is sign
		logic [11:0] base_code;     // Variable-scale base measurement
		logic [9:0]  estimate_one;  // First estimated measurement
		logic [9:0]  estimate_two;  // Second estimated measurement
	} sweep_grp_t;

	// Packed group word and its XOR
	typedef struct packed
	{
		logic [GRP_BITS-1:0] word;
		logic [7:0]          xsum;
	} packed_grp_t;

endpackage

//--- logic/group_packer.sv
// Purpose: Packs one measurement group into its wire word and byte XOR.
// Assumes: Pure combinational; the caller registers the result.
// Notes:   Word is sent from bit 0 upward, one byte at a time.
`timescale 1ns/100ps
module group_packer
(
	input  wire logic                  ext_mode,
	input  wire sweep_pkg::sweep_grp_t grp,
	output      sweep_pkg::packed_grp_t res
);
	import sweep_pkg::*;

	// Build the word for the selected format and fold its bytes
	always_comb
	begin
		res = '0;
		if (ext_mode)
		begin
			// Extended group: base code, then two estimates
			res.word = {8'h00, grp.estimate_two, grp.estimate_one, grp.base_code};
		end
		else
		begin
			// Legacy group: two ranges then two corrections
			res.word = {grp.corr_second, grp.corr_first,
				grp.range_second, grp.range_first};
		end
		res.xsum = res.word[7:0] ^ res.word[15:8] ^ res.word[23:16]
			^ res.word[31:24] ^ res.word[39:32];
	end

endmodule

//--- logic/sweep_framer.sv
// Purpose: Collects measurement groups and emits sweep packets byte by byte.
// Assumes: Byte link with valid/ready; requests arrive as one-cycle pulses.
// Notes:   A whole packet is gathered first, since the check field leads it.
`timescale 1ns/100ps
module sweep_framer
(
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic                  req_start,
	input  wire logic [7:0]            req_mode,
	input  wire logic                  req_other,
	input  wire logic                  fault,
	input  wire logic                  grp_valid,
	input  wire sweep_pkg::sweep_grp_t grp_in,
	output      logic                  grp_ready,
	output      logic                  tx_valid,
	output      logic [7:0]            tx_data,
	input  wire logic                  tx_ready,
	output      logic                  sweeping
);
	import sweep_pkg::*;

	fr_state_t              state_r, state_nxt;      // Framer state
	logic                   ext_r, ext_nxt;          // Extended format selected
	logic [GRP_BITS-1:0]    buf_r [EXT_GROUPS];      // Group words of one packet
	logic [GRP_BITS-1:0]    buf_nxt [EXT_GROUPS];
	logic [IDX_W-1:0]       wr_r, wr_nxt;            // Next group slot to fill
	logic [IDX_W-1:0]       rd_r, rd_nxt;            // Group being sent
	logic [SUB_W-1:0]       sub_r, sub_nxt;          // Byte within group
	logic [HDR_W-1:0]       hdr_r, hdr_nxt;          // Header byte position
	logic [7:0]             acc_r, acc_nxt;          // Running XOR of group bytes
	logic [7:0]             chk_r, chk_nxt;          // Check field of packet
	logic [14:0]            head_r, head_nxt;        // Reference heading of packet
	logic                   flag_r, flag_nxt;        // New-rotation flag of packet
	logic                   armed_r, armed_nxt;      // Waiting for first rotation
	logic                   havep_r, havep_nxt;      // A previous angle is held
	logic [14:0]            prev_r, prev_nxt;        // Previous raw angle
	logic                   gready_r, gready_nxt;    // Group input ready
	logic                   tval_r, tval_nxt;        // Byte output valid
	logic [7:0]             tdat_r, tdat_nxt;        // Byte output data
	logic                   sweep_r, sweep_nxt;      // Sweeping output
	packed_grp_t            pk;                      // Packed incoming group
	logic [IDX_W-1:0]       last_grp;                // Last group index of format
	logic [SUB_W-1:0]       last_sub;                // Last byte index in group
	logic [GRP_BITS-1:0]    cur_word;                // Word being sent
	logic                   take;                    // Group accepted
	logic                   load;                    // Output register may load
	logic                   stop;                    // Leave sweeping

	// Packs incoming group for the current format
	group_packer u_pack
	(
		.ext_mode (ext_r),
		.grp      (grp_in),
		.res      (pk)
	);

	assign last_grp  = ext_r ? EXT_LAST_GRP : LEG_LAST_GRP;
	assign last_sub  = ext_r ? EXT_LAST_SUB : LEG_LAST_SUB;
	assign cur_word  = buf_r[rd_r];
	assign take      = grp_valid && gready_r;
	assign load      = !tval_r || tx_ready;
	assign stop      = req_other || fault;

	// Next state for control, collection and transmission
	always_comb
	begin
		state_nxt  = state_r;
		ext_nxt    = ext_r;
		wr_nxt     = wr_r;
		rd_nxt     = rd_r;
		sub_nxt    = sub_r;
		hdr_nxt    = hdr_r;
		acc_nxt    = acc_r;
		chk_nxt    = chk_r;
		head_nxt   = head_r;
		flag_nxt   = flag_r;
		armed_nxt  = armed_r;
		havep_nxt  = havep_r;
		prev_nxt   = prev_r;
		tval_nxt   = tval_r;
		tdat_nxt   = tdat_r;
		buf_nxt    = buf_r;
		if (req_start)
		begin
			// Any start request restarts sweeping in the requested format
			state_nxt = ST_COLLECT;
			ext_nxt   = (req_mode != MODE_LEGACY);
			wr_nxt    = '0;
			acc_nxt   = '0;
			flag_nxt  = 1'b0;
			armed_nxt = 1'b1;
			havep_nxt = 1'b0;
			tval_nxt  = 1'b0;
		end
		else if (stop)
		begin
			// Abandon the packet in flight
			state_nxt = ST_IDLE;
			tval_nxt  = 1'b0;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE:
				begin
					tval_nxt = 1'b0;
				end
				ST_COLLECT:
				begin
					if (take)
					begin
						// Store the group and fold its bytes in
						buf_nxt[wr_r] = pk.word;
						acc_nxt       = acc_r ^ pk.xsum;
						prev_nxt      = grp_in.heading;
						havep_nxt     = 1'b1;
						if (wr_r == '0)
						begin
							head_nxt = grp_in.heading;
						end
						if (armed_r && havep_r && (grp_in.heading < prev_r))
						begin
							// First group of the first rotation
							flag_nxt  = 1'b1;
							armed_nxt = 1'b0;
						end
						if (wr_r == last_grp)
						begin
							state_nxt = ST_SEND;
							hdr_nxt   = HB_MARK0;
							rd_nxt    = '0;
							sub_nxt   = '0;
						end
						wr_nxt = wr_r + 1'b1;
					end
				end
				ST_SEND:
				begin
					// Check field covers heading bytes, never marker bytes
					chk_nxt = acc_r ^ head_r[7:0] ^ {flag_r, head_r[14:8]};
					if (load)
					begin
						tval_nxt = 1'b1;
						unique case (hdr_r)
							HB_MARK0:
							begin
								tdat_nxt = {MARK_FIRST, chk_nxt[3:0]};
								hdr_nxt  = HB_MARK1;
							end
							HB_MARK1:
							begin
								tdat_nxt = {MARK_SECOND, chk_r[7:4]};
								hdr_nxt  = HB_HEAD0;
							end
							HB_HEAD0:
							begin
								tdat_nxt = head_r[7:0];
								hdr_nxt  = HB_HEAD1;
							end
							HB_HEAD1:
							begin
								tdat_nxt = {flag_r, head_r[14:8]};
								hdr_nxt  = HB_DONE;
							end
							HB_DONE:
							begin
								// Group bytes, low byte first
								tdat_nxt = cur_word[{sub_r, 3'b000} +: 8];
								if (sub_r == last_sub)
								begin
									sub_nxt = '0;
									rd_nxt  = rd_r + 1'b1;
									if (rd_r == last_grp)
									begin
										// Last byte loaded; the group index may wrap, so close by position
										hdr_nxt = HB_TAIL;
									end
								end
								else
								begin
									sub_nxt = sub_r + 1'b1;
								end
							end
							HB_TAIL:
							begin
								// Packet done: gather the next one at once
								tval_nxt  = 1'b0;
								state_nxt = ST_COLLECT;
								wr_nxt    = '0;
								acc_nxt   = '0;
								flag_nxt  = 1'b0;
							end
							default:
							begin
								hdr_nxt = HB_MARK0;
							end
						endcase
					end
				end
				default:
				begin
					state_nxt = ST_IDLE;
				end
			endcase
		end
		gready_nxt = (state_nxt == ST_COLLECT) && !((state_r == ST_COLLECT) && take
			&& (wr_r == last_grp)) && !req_start;
		sweep_nxt  = (state_nxt != ST_IDLE);
	end

	// Registers of the framer
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state_r  <= ST_IDLE;
			ext_r    <= 1'b0;
			wr_r     <= '0;
			rd_r     <= '0;
			sub_r    <= '0;
			hdr_r    <= HB_MARK0;
			acc_r    <= '0;
			chk_r    <= '0;
			head_r   <= '0;
			flag_r   <= 1'b0;
			armed_r  <= 1'b0;
			havep_r  <= 1'b0;
			prev_r   <= '0;
			gready_r <= 1'b0;
			tval_r   <= 1'b0;
			tdat_r   <= '0;
			sweep_r  <= 1'b0;
		end
		else
		begin
			state_r  <= state_nxt;
			ext_r    <= ext_nxt;
			wr_r     <= wr_nxt;
			rd_r     <= rd_nxt;
			sub_r    <= sub_nxt;
			hdr_r    <= hdr_nxt;
			acc_r    <= acc_nxt;
			chk_r    <= chk_nxt;
			head_r   <= head_nxt;
			flag_r   <= flag_nxt;
			armed_r  <= armed_nxt;
			havep_r  <= havep_nxt;
			prev_r   <= prev_nxt;
			gready_r <= gready_nxt;
			tval_r   <= tval_nxt;
			tdat_r   <= tdat_nxt;
			sweep_r  <= sweep_nxt;
		end
	end

	// Packet storage, one word per group slot
	genvar gi;
	generate
		for (gi = 0; gi < EXT_GROUPS; gi++)
		begin : g_buf
			always_ff @(posedge clk)
			begin
				if (!nrst)
				begin
					buf_r[gi] <= '0;
				end
				else
				begin
					buf_r[gi] <= buf_nxt[gi];
				end
			end
		end
	endgenerate

	assign grp_ready = gready_r;
	assign tx_valid  = tval_r;
	assign tx_data   = tdat_r;
	assign sweeping  = sweep_r;

endmodule

//--- dv/sweep_framer_monitor.sv
// Purpose: Port-level checks of the sweep framer.
// Assumes: One clock, synchronous active-low reset.
// Notes:   A helper counter tracks the byte position in a packet.
`timescale 1ns/100ps
module sweep_framer_monitor
(
	input wire logic                  clk,
	input wire logic                  nrst,
	input wire logic                  req_start,
	input wire logic [7:0]            req_mode,
	input wire logic                  req_other,
	input wire logic                  fault,
	input wire logic                  grp_valid,
	input wire sweep_pkg::sweep_grp_t grp_in,
	input wire logic                  grp_ready,
	input wire logic                  tx_valid,
	input wire logic [7:0]            tx_data,
	input wire logic                  tx_ready,
	input wire logic                  sweeping
);
	import sweep_pkg::*;
	logic [7:0] bc_r;    // Bytes taken in this packet
	logic [7:0] bc_nxt;
	logic       ext_r;   // Extended format selected
	logic       ext_nxt;
	logic       halt;    // Start, stop or fault
	logic       last;    // Final byte of a packet taken
	assign halt = req_start || req_other || fault;
	assign last = tx_valid && tx_ready && bc_r == (ext_r ? 8'h83 : 8'h53);
	// Byte position restarts at each packet, start or stop
	always_comb
	begin
		ext_nxt = req_start ? req_mode != 8'h00 : ext_r;
		bc_nxt  = (halt || last) ? 8'h00 : bc_r + 8'(tx_valid && tx_ready);
	end
	// Register the helper state
	always_ff @(posedge clk)
	begin
		if (!nrst)
			{ext_r, bc_r} <= '0;
		else
			{ext_r, bc_r} <= {ext_nxt, bc_nxt};
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	a_start_collect: assert property (req_start ##1 !halt |=> grp_ready && sweeping)
		else $error("no collection after start");
	a_stop_quiet: assert property ((req_other || fault) && !req_start |=> !tx_valid && !sweeping)
		else $error("output after stop");
	a_idle_quiet: assert property (!sweeping |-> !grp_ready && !tx_valid)
		else $error("activity while idle");
	a_byte_hold: assert property (tx_valid && !tx_ready && !halt |=> tx_valid && $stable(tx_data))
		else $error("byte changed before taken");
	a_mark_first: assert property (tx_valid && bc_r == 8'h00 |-> tx_data[7:4] == 4'ha)
		else $error("first marker wrong");
	a_mark_second: assert property (tx_valid && bc_r == 8'h01 |-> tx_data[7:4] == 4'h5)
		else $error("second marker wrong");
	a_send_apart: assert property (tx_valid |-> !grp_ready)
		else $error("collecting while sending");
	a_next_packet: assert property (last && !halt |=> !tx_valid ##[1:2] grp_ready)
		else $error("packet length or repeat wrong");
endmodule

//--- dv/host_model.sv
// Purpose: Host end of the byte link, taking packet bytes.
// Assumes: Byte taken at an edge with valid and ready high.
// Notes:   Not ready one cycle in four, to stall the framer.
`timescale 1ns/100ps
module host_model
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output      logic       tx_ready = 1'b0
);
	logic [1:0] ph_r = 2'h0;  // Stall phase
	logic [7:0] got[$];       // Bytes received, oldest first
	// Take bytes and stall periodically
	always @(posedge clk)
	begin
		ph_r <= nrst ? ph_r + 2'h1 : 2'h0;
		tx_ready <= nrst && ph_r != 2'h2;
		if (nrst && tx_valid && tx_ready)
			got.push_back(tx_data);
	end
endmodule

//--- dv/testbench.sv
// Purpose: Self-checking bench for the sweep framer.
// Assumes: Host model collects bytes; the bench offers groups.
// Notes:   Expected packets are rebuilt from the group formula.
`timescale 1ns/100ps
module testbench;
	import sweep_pkg::*;
	typedef logic [7:0] bytes_t[$];
	logic       clk       = 1'b0;
	logic       nrst      = 1'b0;
	logic       req_start = 1'b0;
	logic       req_other = 1'b0;
	logic       fault     = 1'b0;
	logic       grp_valid = 1'b0;
	logic [7:0] req_mode  = 8'h00;
	logic [7:0] gn        = 8'h00;  // Index of group on offer
	logic [2:0] cyc       = 3'h0;   // Gap pacing of groups
	logic       grp_ready;
	logic       tx_valid;
	logic       tx_ready;
	logic       sweeping;
	logic [7:0] tx_data;
	sweep_grp_t grp_in;
	int         mismatches      = 0;
	int         samples_checked = 0;
	always #5 clk = ~clk;
	assign grp_in = mk(gn);
	sweep_framer i_sweep_framer (.clk, .nrst, .req_start, .req_mode, .req_other, .fault,
		.grp_valid, .grp_in, .grp_ready, .tx_valid, .tx_data, .tx_ready, .sweeping);
	host_model i_host_model (.clk, .nrst, .tx_valid, .tx_data, .tx_ready);
	// Offer groups, one gap after a take in every fifth cycle
	always @(posedge clk)
	begin
		cyc <= (cyc == 3'h4) ? 3'h0 : cyc + 3'h1;
		grp_valid <= nrst && !(grp_valid && grp_ready && cyc == 3'h0);
		if (req_start)
			gn <= 8'h00;
		else if (grp_valid && grp_ready)
			gn <= gn + 8'h01;
	end
	function automatic logic [14:0] hd(input logic [7:0] n);
		return 15'((32'(n) * 32'h44c) % 32'h5a00);
	endfunction
	function automatic sweep_grp_t mk(input logic [7:0] n);
		sweep_grp_t g;
		g.heading      = hd(n);
		g.range_first  = {n, ~n};
		g.range_second = n[1] ? 16'h0000 : {~n, n};
		g.corr_first   = n[3:0];
		g.corr_second  = ~n[3:0];
		g.base_code    = {n[3:0], n};
		g.estimate_one = {2'h2, n};
		g.estimate_two = {~n, 2'h1};
		return g;
	endfunction
	// Expected bytes of packet k after a start
	function automatic bytes_t build(input int k, input logic ext, inout logic seen);
		bytes_t      q;
		sweep_grp_t  g;
		logic [39:0] w;
		logic [7:0]  x;
		logic        fl;
		int          ng;
		ng = ext ? 32 : 16;
		fl = 1'b0;
		x = 8'h00;
		for (int i = k * ng; i < (k + 1) * ng; i++)
		begin
			if (i > 0 && !seen && hd(8'(i)) < hd(8'(i - 1)))
			begin
				fl = 1'b1;
				seen = 1'b1;
			end
			g = mk(8'(i));
			w = ext ? {8'h00, g.estimate_two, g.estimate_one, g.base_code}
				: {g.corr_second, g.corr_first, g.range_second, g.range_first};
			for (int b = 0; b < (ext ? 4 : 5); b++)
				q.push_back(w[8 * b +: 8]);
		end
		q.push_front({fl, 7'(hd(8'(k * ng)) >> 8)});
		q.push_front(8'(hd(8'(k * ng))));
		foreach (q[j])
			x ^= q[j];
		q.push_front({4'h5, x[7:4]});
		q.push_front({4'ha, x[3:0]});
		return q;
	endfunction
	task automatic check(input logic [7:0] seen_v, input logic [7:0] exp_v);
		samples_checked++;
		if (seen_v !== exp_v)
		begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen_v, exp_v);
		end
	endtask
	// Start a sweep and compare npk packets in a row
	task automatic run_mode(input logic [7:0] mode, input int npk);
		bytes_t e;
		logic   seen;
		seen = 1'b0;
		@(posedge clk);
		req_mode <= mode;
		req_start <= 1'b1;
		@(posedge clk);
		req_start <= 1'b0;
		repeat (2) @(posedge clk);
		i_host_model.got.delete();
		for (int k = 0; k < npk; k++)
		begin
			e = build(k, mode != 8'h00, seen);
			for (int t = 0; t < 3000 && i_host_model.got.size() < e.size(); t++)
				@(posedge clk);
			check(8'(i_host_model.got.size() >= e.size()), 8'h01);
			foreach (e[j])
				check(i_host_model.got.pop_front(), e[j]);
		end
		$display("test mode %h done", mode);
	endtask
	// Stop in mid-packet by request or by fault
	task automatic stop_run(input logic use_fault);
		for (int t = 0; t < 3000 && tx_valid !== 1'b1; t++)
			@(negedge clk);
		@(posedge clk);
		req_other <= !use_fault;
		fault <= use_fault;
		@(posedge clk);
		req_other <= 1'b0;
		repeat (3) @(posedge clk);
		fault <= 1'b0;
		@(negedge clk);
		check(8'({tx_valid, sweeping, grp_ready}), 8'h00);
		repeat (200) @(negedge clk);
		check(8'({tx_valid, sweeping}), 8'h00);
		$display("test stop %0d done", use_fault);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog against a hang
	initial
	begin
		#200000;
		mismatches++;
		tally_and_finish();
	end
	// Main sequence
	initial
	begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		run_mode(8'h00, 3);
		stop_run(1'b0);
		run_mode(8'h02, 2);
		stop_run(1'b1);
		run_mode(8'h00, 1);
		run_mode(8'hff, 1);
		tally_and_finish();
	end
endmodule
bind sweep_framer sweep_framer_monitor i_sweep_framer_monitor (.clk, .nrst, .req_start,
	.req_mode, .req_other, .fault, .grp_valid, .grp_in, .grp_ready, .tx_valid, .tx_data,
	.tx_ready, .sweeping);
